// ---- design/amp_pipe_ctrl.sv ----
// Function
// RQ1: Arithmetic ops flow fetch, decode, execute, idle, writeback
// RQ2: Idle memory stage holds result unchanged
// RQ3: Destination register written only at writeback
// RQ4: Flag arithmetic uses five stages, interlocks readers
// RQ5: Test ops five stages, interlock status readers
// RQ6: Logic ops hold result, write at writeback
// RQ7: Word MAC: two memory, three multiplier stages
// RQ8: Multiplier busy three cycles, regardless of slots
// RQ9: Follower of word MAC stalls one slot
// RQ10: Multiplier user waits while multiplier busy
// RQ11: Memory stages yield to fetch contention arbitration
// RQ12: Long MAC same flow, one slot stall
// RQ13: DSP word MAC has two multiplier stages
// RQ14: DSP long multiplies have four multiplier stages
// RQ15: 16-bit multiply: one memory, two busy cycles
// RQ16: 16-bit multiply needs no follower stall
// RQ17: Double multiply: two memory, three busy cycles
// RQ18: Follower of double multiply stalls one slot
// RQ19: Memory logic runs two memory stages, stall two
// RQ20: Busy countdown gates multiplier users in decode
// RQ21: Status readers wait for pending flag writeback
module amp_pipe_ctrl #(
	parameter bit DSP_VARIANT = 1'b0
) (
	input  wire logic                     core_clk_i,
	input  wire logic                     arst_n_i,
	input  wire logic                     dec_valid_i,
	input  wire amp_pkg::amp_op_e         dec_op_i,
	input  wire logic                     dec_reads_sr_i,
	input  wire logic [amp_pkg::REG_ADDR_W-1:0] dec_dest_i,
	input  wire logic [amp_pkg::DATA_W-1:0]     ex_result_i,
	input  wire logic                     ex_sr_t_i,
	input  wire logic                     mem_grant_i,
	output logic                          dec_ready_o,
	output logic                          mem_req_o,
	output logic                          mul_load_o,
	output logic                          mul_busy_o,
	output logic                          wb_en_o,
	output logic [amp_pkg::REG_ADDR_W-1:0] wb_dest_o,
	output logic [amp_pkg::DATA_W-1:0]    wb_data_o,
	output logic                          sr_wr_en_o,
	output logic                          sr_t_o
);
	import amp_pkg::*;

	typedef enum logic [2:0] {
		AMP_EX_IDLE = 3'b000,
		AMP_EX_RUN  = 3'b001,
		AMP_EX_MA1  = 3'b011,
		AMP_EX_MA2  = 3'b010,
		AMP_EX_EX2  = 3'b110
	} amp_ex_state_e;

	amp_ex_state_e ex_state;
	amp_op_e       ex_op;
	logic [REG_ADDR_W-1:0] ex_dest;
	logic [1:0]    ma_left;
	logic [1:0]    follow_stall;

	// Idle memory stage slot
	logic          ma_valid;
	logic          ma_wb;
	logic          ma_sr;
	logic [REG_ADDR_W-1:0] ma_dest;
	logic [DATA_W-1:0]     ma_data;
	logic          ma_t;

	logic          mul_busy;
	logic          sr_stall;
	logic          mul_stall;
	logic          ex_free;
	logic          issue;
	logic          ex_done;
	logic [2:0]    mul_count;

	function automatic logic [1:0] amp_ma_count(input amp_op_e op);
		unique case (op)
			AMP_OP_WORD_MULTIPLY_ACCUMULATE, AMP_OP_LONG_MULTIPLY_ACCUMULATE, AMP_OP_MUL_DBL, AMP_OP_MEM_LOGIC: return MA_COUNT_TWO;
			default: return MA_COUNT_ONE;
		endcase
	endfunction

	function automatic logic [2:0] amp_busy_count(input amp_op_e op);
		unique case (op)
			AMP_OP_WORD_MULTIPLY_ACCUMULATE: return DSP_VARIANT ? MUL_BUSY_WORD_MULTIPLY_ACCUMULATE_DSP : MUL_BUSY_WORD_MULTIPLY_ACCUMULATE; // RQ7 RQ13
			AMP_OP_LONG_MULTIPLY_ACCUMULATE, AMP_OP_MUL_DBL: return DSP_VARIANT ? MUL_BUSY_LONG_DSP : MUL_BUSY_LONG; // RQ12 RQ14 RQ17
			AMP_OP_MUL_16: return MUL_BUSY_16; // RQ15
			default: return 3'h0;
		endcase
	endfunction

	function automatic logic amp_has_ma(input amp_op_e op);
		return amp_uses_mul(op) || (op == AMP_OP_MEM_LOGIC);
	endfunction

	function automatic logic amp_writes_gpr(input amp_op_e op);
		return (op == AMP_OP_ARITH) || (op == AMP_OP_ARITH_SR) || (op == AMP_OP_LOGIC);
	endfunction

	amp_sr_interlock u_sr (
		.core_clk_i        (core_clk_i),
		.arst_n_i          (arst_n_i),
		.issue_i           (issue),
		.issue_sets_sr_i   (amp_sets_sr(dec_op_i)),
		.sr_write_i        (sr_wr_en_o),
		.decode_reads_sr_i (dec_valid_i && dec_reads_sr_i),
		.stall_o           (sr_stall)
	);

	amp_mul_busy u_mul (
		.core_clk_i   (core_clk_i),
		.arst_n_i     (arst_n_i),
		.load_i       (mul_load_o),
		.load_count_i (amp_busy_count(ex_op)),
		.busy_o       (mul_busy),
		.count_o      (mul_count)
	);

	// Multiplier user held while countdown or a queued multiply is live
	assign mul_stall = dec_valid_i && amp_uses_mul(dec_op_i) &&
		(mul_busy || (ex_state != AMP_EX_IDLE && amp_uses_mul(ex_op))); // RQ10 RQ20

	// Memory stage finishes only when the fetch arbiter grants the slot
	assign ex_done = ((ex_state == AMP_EX_MA1) || (ex_state == AMP_EX_MA2)) && mem_grant_i; // RQ11

	assign ex_free = (ex_state == AMP_EX_IDLE) ||
		((ex_state == AMP_EX_RUN) && (follow_stall == 2'h0) && !amp_has_ma(ex_op));

	assign issue       = dec_valid_i && ex_free && !sr_stall && !mul_stall;
	assign dec_ready_o = ex_free && !sr_stall && !mul_stall;
	assign mem_req_o   = (ex_state == AMP_EX_MA1) || (ex_state == AMP_EX_MA2);
	assign mul_busy_o  = mul_busy;

	// Multiplier loaded as the final memory stage ends
	assign mul_load_o = ex_done && (ma_left == 2'h1) && amp_uses_mul(ex_op); // RQ7 RQ15 RQ17

	// Execute and memory stage sequencing
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ex_state     <= AMP_EX_IDLE;
			ex_op        <= AMP_OP_NONE;
			ex_dest      <= '0;
			ma_left      <= 2'h0;
			follow_stall <= 2'h0;
		end else begin
			unique case (ex_state)
				AMP_EX_IDLE, AMP_EX_RUN: begin
					if (ex_state == AMP_EX_RUN && amp_has_ma(ex_op)) begin
						ex_state <= AMP_EX_MA1;
						ma_left  <= amp_ma_count(ex_op);
					end else if (follow_stall != 2'h0) begin
						follow_stall <= follow_stall - 2'h1; // RQ9 RQ12 RQ18 RQ19
						if (follow_stall == 2'h1) begin
							ex_state <= AMP_EX_IDLE;
						end
					end else if (issue) begin
						ex_state <= AMP_EX_RUN;
						ex_op    <= dec_op_i;
						ex_dest  <= dec_dest_i;
					end else begin
						ex_state <= AMP_EX_IDLE;
						ex_op    <= AMP_OP_NONE;
					end
				end
				AMP_EX_MA1: begin
					if (ex_done) begin
						if (ma_left == 2'h1) begin
							// Single memory stage: follower flows normally
							ex_state <= AMP_EX_IDLE; // RQ16
						end else if (ex_op == AMP_OP_MEM_LOGIC) begin
							ex_state <= AMP_EX_EX2; // RQ19
						end else begin
							ex_state <= AMP_EX_MA2; // RQ7 RQ17
						end
						ma_left <= ma_left - 2'h1;
					end
				end
				AMP_EX_EX2: begin
					ex_state <= AMP_EX_MA2; // RQ19
				end
				AMP_EX_MA2: begin
					if (ex_done) begin
						ma_left      <= 2'h0;
						ex_state     <= AMP_EX_RUN;
						ex_op        <= AMP_OP_NONE;
						follow_stall <= (ex_op == AMP_OP_MEM_LOGIC) ? STALL_MEM_LOGIC : STALL_MULTI_MA; // RQ9 RQ18 RQ19
					end
				end
				default: begin
					ex_state <= AMP_EX_IDLE;
				end
			endcase
		end
	end

	// Idle memory stage: reload every cycle, pass the value on untouched
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ma_valid <= 1'b0;
			ma_wb    <= 1'b0;
			ma_sr    <= 1'b0;
			ma_dest  <= '0;
			ma_data  <= '0;
			ma_t     <= 1'b0;
		end else begin
			ma_valid <= (ex_state == AMP_EX_RUN) && !amp_has_ma(ex_op) && (ex_op != AMP_OP_NONE); // RQ1
			ma_wb    <= amp_writes_gpr(ex_op); // RQ3 RQ6
			ma_sr    <= amp_sets_sr(ex_op); // RQ4 RQ5
			ma_dest  <= ex_dest;
			ma_data  <= ex_result_i; // RQ2
			ma_t     <= ex_sr_t_i;
		end
	end

	// Writeback stage: the only place registers and flags change
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wb_en_o    <= 1'b0;
			wb_dest_o  <= '0;
			wb_data_o  <= '0;
			sr_wr_en_o <= 1'b0;
			sr_t_o     <= 1'b0;
		end else begin
			wb_en_o    <= ma_valid && ma_wb; // RQ3 RQ1 RQ6
			wb_dest_o  <= ma_dest;
			wb_data_o  <= ma_data; // RQ2
			sr_wr_en_o <= ma_valid && ma_sr; // RQ4 RQ5
			sr_t_o     <= ma_t;
		end
	end
endmodule

// ---- design/amp_pkg.sv ----
package amp_pkg;

	localparam int unsigned REG_ADDR_W = 4;
	localparam int unsigned DATA_W     = 32;

	// Instruction classes seen by the sequencer
	typedef enum logic [3:0] {
		AMP_OP_NONE     = 4'h0,
		AMP_OP_ARITH    = 4'h1,
		AMP_OP_ARITH_SR = 4'h2,
		AMP_OP_LOGIC    = 4'h3,
		AMP_OP_TEST_SR  = 4'h4,
		AMP_OP_WORD_MULTIPLY_ACCUMULATE    = 4'h5,
		AMP_OP_LONG_MULTIPLY_ACCUMULATE    = 4'h6,
		AMP_OP_MUL_16   = 4'h7,
		AMP_OP_MUL_DBL  = 4'h8,
		AMP_OP_MEM_LOGIC = 4'h9,
		AMP_OP_OTHER    = 4'hA
	} amp_op_e;

	// Multiplier busy cycles after the last memory stage
	localparam logic [2:0] MUL_BUSY_WORD_MULTIPLY_ACCUMULATE      = 3'h3;
	localparam logic [2:0] MUL_BUSY_WORD_MULTIPLY_ACCUMULATE_DSP  = 3'h2;
	localparam logic [2:0] MUL_BUSY_LONG       = 3'h3;
	localparam logic [2:0] MUL_BUSY_LONG_DSP   = 3'h4;
	localparam logic [2:0] MUL_BUSY_16         = 3'h2;

	// Extra decode stall slots of the follower
	localparam logic [1:0] STALL_MULTI_MA = 2'h1;
	localparam logic [1:0] STALL_MEM_LOGIC = 2'h2;

	// Memory stage counts
	localparam logic [1:0] MA_COUNT_ONE = 2'h1;
	localparam logic [1:0] MA_COUNT_TWO = 2'h2;

	// Flag update hazard reach, in instructions
	localparam int unsigned SR_HAZARD_DEPTH = 2;

	function automatic logic amp_uses_mul(input amp_op_e op);
		return (op == AMP_OP_WORD_MULTIPLY_ACCUMULATE) || (op == AMP_OP_LONG_MULTIPLY_ACCUMULATE) ||
			(op == AMP_OP_MUL_16) || (op == AMP_OP_MUL_DBL);
	endfunction

	function automatic logic amp_sets_sr(input amp_op_e op);
		return (op == AMP_OP_ARITH_SR) || (op == AMP_OP_TEST_SR);
	endfunction

endpackage

// ---- design/amp_mul_busy.sv ----
module amp_mul_busy (
	input  wire logic       core_clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       load_i,
	input  wire logic [2:0] load_count_i,
	output logic            busy_o,
	output logic [2:0]      count_o
);
	import amp_pkg::*;

	logic [2:0] count;

	// Runs every cycle, independent of pipeline stalls
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count <= 3'h0;
		end else if (load_i) begin
			count <= load_count_i; // RQ20
		end else if (count != 3'h0) begin
			count <= count - 3'h1; // RQ8
		end
	end

	assign busy_o  = (count != 3'h0);
	assign count_o = count;
endmodule

// ---- design/amp_sr_interlock.sv ----
module amp_sr_interlock (
	input  wire logic core_clk_i,
	input  wire logic arst_n_i,
	input  wire logic issue_i,
	input  wire logic issue_sets_sr_i,
	input  wire logic sr_write_i,
	input  wire logic decode_reads_sr_i,
	output logic      stall_o
);
	import amp_pkg::*;

	// Outstanding flag writers, saturating
	logic [1:0] pending;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pending <= 2'h0;
		end else begin
			case ({issue_i && issue_sets_sr_i, sr_write_i})
				// Third writer still in flight when the first writes back
				2'b10: pending <= (pending == 2'(SR_HAZARD_DEPTH + 1)) ? pending : pending + 2'h1; // RQ21
				2'b01: pending <= (pending == 2'h0) ? pending : pending - 2'h1;
				default: pending <= pending;
			endcase
		end
	end

	assign stall_o = decode_reads_sr_i && (pending != 2'h0); // RQ21 RQ4 RQ5
endmodule

// ---- verif/amp_mem_model.sv ----
module amp_mem_model (
	input  wire logic       core_clk_i,
	input  wire logic       arst_n_i,
	input  wire logic       req_i,
	input  wire logic [1:0] lag_i,
	output logic            grant_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] wait_cnt;
	// Fetch may own the slot first, so the grant lags
	assign grant_o = req_i && (wait_cnt >= lag_i);
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			wait_cnt <= 2'h0;
		else
			wait_cnt <= (req_i && !grant_o) ? wait_cnt + 2'h1 : 2'h0;
	end
endmodule

// ---- verif/amp_pipe_props.sv ----
module amp_pipe_props
	import amp_pkg::*;
#(
	parameter bit DSP_VARIANT = 1'b0
) (
	input wire logic          core_clk_i,
	input wire logic          arst_n_i,
	input wire logic          dec_valid_i,
	input wire amp_op_e       dec_op_i,
	input wire logic          dec_reads_sr_i,
	input wire logic [3:0]    dec_dest_i,
	input wire logic [31:0]   ex_result_i,
	input wire logic          ex_sr_t_i,
	input wire logic          mem_grant_i,
	input wire logic          dec_ready_o,
	input wire logic          mem_req_o,
	input wire logic          mul_load_o,
	input wire logic          mul_busy_o,
	input wire logic          wb_en_o,
	input wire logic [3:0]    wb_dest_o,
	input wire logic [31:0]   wb_data_o,
	input wire logic          sr_wr_en_o,
	input wire logic          sr_t_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	logic       iss, alu, srw, mul, short_m;
	logic [2:0] pend;
	assign iss = dec_valid_i && dec_ready_o;
	assign alu = dec_op_i inside {AMP_OP_ARITH, AMP_OP_ARITH_SR, AMP_OP_LOGIC};
	assign srw = dec_op_i inside {AMP_OP_ARITH_SR, AMP_OP_TEST_SR};
	assign mul = dec_op_i inside {AMP_OP_WORD_MULTIPLY_ACCUMULATE, AMP_OP_LONG_MULTIPLY_ACCUMULATE, AMP_OP_MUL_16, AMP_OP_MUL_DBL};
	// Three setters can be in flight back to back
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			pend <= 3'h0;
		else
			pend <= pend + 3'(iss && srw) - 3'(sr_wr_en_o);
	end
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			short_m <= 1'b0;
		else if (iss && mul)
			short_m <= (dec_op_i == AMP_OP_MUL_16);
	end
	chk_alu_wb_slot: assert property (iss && alu |-> ##3 wb_en_o && wb_dest_o == $past(dec_dest_i, 3))
		else $error("writeback slot wrong");
	chk_idle_hold: assert property (iss && alu |-> ##3 wb_data_o == $past(ex_result_i, 2))
		else $error("result not held");
	chk_sr_wr_slot: assert property (iss && srw |-> ##3 sr_wr_en_o && sr_t_o == $past(ex_sr_t_i, 2))
		else $error("flag write slot wrong");
	chk_busy_three: assert property (mul_load_o && !short_m && !DSP_VARIANT |=> mul_busy_o[*3] ##1 !mul_busy_o)
		else $error("busy not three");
	chk_busy_two: assert property (mul_load_o && short_m |=> mul_busy_o[*2] ##1 !mul_busy_o)
		else $error("busy not two");
	chk_mul_hold: assert property (dec_valid_i && mul && mul_busy_o |-> !dec_ready_o)
		else $error("multiplier user issued");
	chk_mem_wait: assert property (mem_req_o && !mem_grant_i |=> mem_req_o)
		else $error("memory request dropped");
	chk_mem_block: assert property (mem_req_o |-> !dec_ready_o)
		else $error("issue during memory stage");
	chk_follow_stall: assert property (mul_load_o && !short_m |=> !dec_ready_o)
		else $error("follower not stalled");
	chk_sr_block: assert property (dec_valid_i && dec_reads_sr_i && pend != 3'h0 && !sr_wr_en_o |-> !dec_ready_o)
		else $error("flag reader issued");
endmodule
bind amp_pipe_ctrl amp_pipe_props #(.DSP_VARIANT(DSP_VARIANT)) amp_pipe_props_inst (.*);

// ---- verif/amp_pipe_ctrl_tb_top.sv ----
module amp_pipe_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import amp_pkg::*;
	logic        core_clk_i = 1'b0;
	logic        arst_n_i = 1'b0;
	logic        dec_valid_i = 1'b0;
	logic        dec_reads_sr_i = 1'b0;
	logic        ex_sr_t_i = 1'b0;
	amp_op_e     dec_op_i = AMP_OP_ARITH;
	logic [3:0]  dec_dest_i = 4'h0;
	logic [31:0] ex_result_i = 32'h0;
	logic [1:0]  lag = 2'h0;
	logic        mem_grant_i, dec_ready_o, mem_req_o, mul_load_o, mul_busy_o, wb_en_o, sr_wr_en_o, sr_t_o;
	logic [3:0]  wb_dest_o;
	logic [31:0] wb_data_o;
	logic [38:0] pipe [1:3];
	amp_op_e     mq [$];
	int          num_errors = 0, cmp_count = 0, seed = 62782, cyc = 0, bcnt = 0, bexp = 0;
	logic        bon = 1'b0;
	always #5 core_clk_i = ~core_clk_i;
	amp_pipe_ctrl #(.DSP_VARIANT(1'b0)) amp_pipe_ctrl_inst (.*);
	amp_mem_model amp_mem_model_inst (.core_clk_i, .arst_n_i, .req_i(mem_req_o), .lag_i(lag), .grant_o(mem_grant_i));
	function automatic logic is_gpr(amp_op_e o);
		return o inside {AMP_OP_ARITH, AMP_OP_ARITH_SR, AMP_OP_LOGIC};
	endfunction
	function automatic logic is_srw(amp_op_e o);
		return o inside {AMP_OP_ARITH_SR, AMP_OP_TEST_SR};
	endfunction
	function automatic logic is_mul(amp_op_e o);
		return o inside {AMP_OP_WORD_MULTIPLY_ACCUMULATE, AMP_OP_LONG_MULTIPLY_ACCUMULATE, AMP_OP_MUL_16, AMP_OP_MUL_DBL};
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (e !== s) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// One process owns the seed so the run repeats exactly
	task automatic drive_rand();
		ex_result_i = $random(seed);
		ex_sr_t_i = 1'($random(seed));
		lag = 2'($unsigned($random(seed)) % 3);
	endtask
	task automatic issue(input amp_op_e op, input logic rs);
		int n;
		n = 0;
		dec_valid_i = 1'b1;
		dec_op_i = op;
		dec_reads_sr_i = rs;
		dec_dest_i = 4'($random(seed));
		drive_rand();
		#1;
		while (dec_ready_o !== 1'b1 && n < 60) begin
			@(negedge core_clk_i);
			drive_rand();
			#1;
			n++;
		end
		chk("dec_ready_o", 32'h1, {31'h0, dec_ready_o});
		@(negedge core_clk_i);
	endtask
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		pipe[1] <= {dec_valid_i && dec_ready_o && is_gpr(dec_op_i), dec_valid_i && dec_ready_o && is_srw(dec_op_i),
			dec_dest_i, 33'h0};
		pipe[2] <= {pipe[1][38:33], ex_result_i, ex_sr_t_i};
		pipe[3] <= pipe[2];
		if (dec_valid_i && dec_ready_o && is_mul(dec_op_i))
			mq.push_back(dec_op_i);
		if (cyc == 20000) begin
			chk("cycle limit", 32'h0, 32'h1);
			end_of_test();
		end
	end
	always @(negedge core_clk_i) begin
		// Stimulus also moves on this edge, so look once outputs settle
		#2;
		if (arst_n_i) begin
			chk("wb_en_o", {31'h0, pipe[3][38]}, {31'h0, wb_en_o});
			chk("sr_wr_en_o", {31'h0, pipe[3][37]}, {31'h0, sr_wr_en_o});
		end
		if (arst_n_i && pipe[3][38]) begin
			chk("wb_dest_o", {28'h0, pipe[3][36:33]}, {28'h0, wb_dest_o});
			chk("wb_data_o", pipe[3][32:1], wb_data_o);
		end
		if (arst_n_i && pipe[3][37])
			chk("sr_t_o", {31'h0, pipe[3][0]}, {31'h0, sr_t_o});
		if (arst_n_i && mul_load_o === 1'b1) begin
			bexp = (mq.size() > 0 && mq.pop_front() == AMP_OP_MUL_16) ? 2 : 3;
			bcnt = 0;
			bon = 1'b1;
		end else if (bon && mul_busy_o === 1'b1)
			bcnt++;
		else if (bon) begin
			chk("mul_busy_o cycles", bexp, bcnt);
			bon = 1'b0;
		end
	end
	initial begin
		amp_op_e ops [4] = '{AMP_OP_WORD_MULTIPLY_ACCUMULATE, AMP_OP_LONG_MULTIPLY_ACCUMULATE, AMP_OP_MUL_16, AMP_OP_MUL_DBL};
		repeat (8) @(negedge core_clk_i);
		arst_n_i = 1'b1;
		foreach (ops[i]) begin
			issue(ops[i], 1'b0);
			issue(ops[i], 1'b0);
			issue(AMP_OP_ARITH, 1'b0);
		end
		$display("Test multiplier done");
		issue(AMP_OP_ARITH_SR, 1'b0);
		issue(AMP_OP_ARITH, 1'b1);
		issue(AMP_OP_TEST_SR, 1'b0);
		issue(AMP_OP_LOGIC, 1'b0);
		issue(AMP_OP_OTHER, 1'b1);
		issue(AMP_OP_MEM_LOGIC, 1'b0);
		issue(AMP_OP_LOGIC, 1'b0);
		$display("Test corner done");
		repeat (200)
			issue(amp_op_e'(4'($unsigned($random(seed)) % 10 + 1)), 1'($random(seed)));
		$display("Test random done");
		dec_valid_i = 1'b0;
		repeat (10) @(negedge core_clk_i);
		end_of_test();
	end
endmodule
